// *** macrocell_array_map.vh ***
// Address map, field positions, reset values and cell mode codes of the
// macrocell array. Included by the array top, the macrocell, the checker and the bench.
`ifndef MACROCELL_ARRAY_MAP_VH
`define MACROCELL_ARRAY_MAP_VH

// ==========================================================
// Geometry
`define CELL_COUNT 8
`define TERMS_PER_CELL 8
`define POOL_WIDTH 40
`define SIGNAL_COUNT 20
`define INPUT_PIN_COUNT 12

// ==========================================================
// Register word addresses
`define ADDR_WIDTH 9
`define ADDR_MASK_FIRST 9'h000
`define ADDR_MASK_LAST 9'h07F
`define ADDR_ARCH 9'h100
`define ADDR_TERM_DIS_LO 9'h101
`define ADDR_TERM_DIS_HI 9'h102
`define ADDR_SIG_LO 9'h103
`define ADDR_SIG_HI 9'h104
`define ADDR_SECURITY 9'h105
`define ADDR_STATUS 9'h106

// ==========================================================
// Architecture word fields
`define ARCH_GLOBAL_ZERO 0
`define ARCH_GLOBAL_ONE 1
`define ARCH_LOCAL_LSB 8
`define ARCH_POLARITY_LSB 16
`define ARCH_WRITE_MASK 32'h00FFFF03
`define SECURITY_BIT 0

// ==========================================================
// Reset values
`define ARCH_RESET 32'h00000000
`define WORD_RESET 32'h00000000

// ==========================================================
// Cell modes
`define MODE_REG_OUT 2'h0
`define MODE_COMB_IO 2'h1
`define MODE_COMB_OUT 2'h2
`define MODE_INPUT 2'h3

`endif

// *** macrocell.v ***
// One output macrocell: eight product terms, OR sum, polarity, register,
// output enable choice and feedback choice.
// Assumes the pool and the configuration are stable, synchronous inputs.
`timescale 1ns/1ns
`include "macrocell_array_map.vh"

module macrocell #(
	parameter TERMS = `TERMS_PER_CELL,
	parameter POOL = `POOL_WIDTH
)
(
	// Clock and reset
	input wire clock,
	input wire rst_n,
	// Array and configuration
	input wire [POOL-1:0] pool,
	input wire [TERMS*POOL-1:0] term_masks,
	input wire [TERMS-1:0] term_disable_fuse,
	input wire [1:0] mode,
	input wire invert,
	input wire term0_is_enable,
	// Pins
	input wire oe_pin_n,
	input wire own_pin,
	input wire adjacent_pin,
	output reg pin_out,
	output reg pin_oe_n,
	// State
	output reg state,
	output wire feedback
);

// ==========================================================
// Product terms
wire [TERMS-1:0] term;
genvar t;
generate
	for (t = 0; t < TERMS; t = t + 1)
	begin : g_term
		// A term with no selected inputs is true; a disabled one is dead
		assign term[t] = (&(pool | ~term_masks[t*POOL +: POOL])) &
			~term_disable_fuse[t];
	end
endgenerate

// ==========================================================
// Sum, polarity and enable
wire [TERMS-1:0] data_select;
wire sum;
wire value;
reg enable;
assign data_select = {{(TERMS-1){1'b1}}, ~term0_is_enable};
assign sum = |(term & data_select);
assign value = sum ^ invert;

always @*
begin
	case (mode)
		`MODE_REG_OUT: enable = ~oe_pin_n;
		`MODE_COMB_IO: enable = term[0];
		`MODE_COMB_OUT: enable = 1'b1;
		`MODE_INPUT: enable = 1'b0;
		default: enable = 1'b0;
	endcase
end

// ==========================================================
// Feedback into the array
assign feedback = (mode == `MODE_REG_OUT) ? state :
	(mode == `MODE_COMB_IO) ? own_pin : adjacent_pin;

// ==========================================================
// Register and pin flops
// Combinatorial pins also pass a flop, so they lag the array by one cycle
always @(posedge clock)
begin
	if (!rst_n)
	begin
		state <= 1'b0;
		pin_out <= 1'b1;
		pin_oe_n <= 1'b1;
	end
	else
	begin
		state <= value;
		pin_out <= (mode == `MODE_REG_OUT) ? ~value : value;
		pin_oe_n <= ~enable;
	end
end

endmodule

// *** macrocell_array.v ***
// Programmable sum-of-products array with eight output macrocells and its
// configuration store, reached over a plain register port.
// Assumes synchronous inputs and that the board resolves the I/O pins.
`timescale 1ns/1ns
`include "macrocell_array_map.vh"

module macrocell_array #(
	parameter CELLS = `CELL_COUNT,
	parameter TERMS = `TERMS_PER_CELL,
	parameter INPUTS = `INPUT_PIN_COUNT
)
(
	// Clock and reset
	input wire clock,
	input wire rst_n,
	// Register port
	input wire [`ADDR_WIDTH-1:0] address,
	input wire [31:0] write_data,
	input wire write_strobe,
	input wire read_strobe,
	output reg [31:0] read_data,
	// Device pins
	input wire [INPUTS-1:0] in_pin,
	input wire oe_pin_n,
	input wire [CELLS-1:0] io_in,
	output wire [CELLS-1:0] io_out,
	output wire [CELLS-1:0] io_oe_n
);

localparam POOL = `POOL_WIDTH;
localparam TOTAL_TERMS = CELLS * TERMS;
localparam MASK_WORDS = TOTAL_TERMS * 2;

// ==========================================================
// Configuration store
reg [31:0] mask_mem [0:MASK_WORDS-1];
reg global_arch_bit_zero;
reg global_arch_bit_one;
reg [CELLS-1:0] local_arch_bit;
reg [CELLS-1:0] polarity;
reg [TOTAL_TERMS-1:0] term_disable_fuse;
reg [63:0] signature;
reg secured;

wire in_mask_range;
wire [6:0] mask_index;
assign in_mask_range = (address >= `ADDR_MASK_FIRST) &&
	(address <= `ADDR_MASK_LAST);
assign mask_index = address[6:0];

integer k;
always @(posedge clock)
begin
	if (!rst_n)
	begin
		for (k = 0; k < MASK_WORDS; k = k + 1)
			mask_mem[k] <= `WORD_RESET;
		global_arch_bit_zero <= 1'b0;
		global_arch_bit_one <= 1'b0;
		local_arch_bit <= {CELLS{1'b0}};
		polarity <= {CELLS{1'b0}};
		term_disable_fuse <= {TOTAL_TERMS{1'b0}};
		signature <= 64'h0000000000000000;
		secured <= 1'b0;
	end
	else if (write_strobe)
	begin
		if (in_mask_range)
			mask_mem[mask_index] <= write_data;
		case (address)
			`ADDR_ARCH:
			begin
				global_arch_bit_zero <= write_data[`ARCH_GLOBAL_ZERO];
				global_arch_bit_one <= write_data[`ARCH_GLOBAL_ONE];
				local_arch_bit <= write_data[`ARCH_LOCAL_LSB +: CELLS];
				polarity <= write_data[`ARCH_POLARITY_LSB +: CELLS];
			end
			`ADDR_TERM_DIS_LO: term_disable_fuse[31:0] <= write_data;
			`ADDR_TERM_DIS_HI: term_disable_fuse[63:32] <= write_data;
			`ADDR_SIG_LO: signature[31:0] <= write_data;
			`ADDR_SIG_HI: signature[63:32] <= write_data;
			// Once set, only reset clears it: software cannot unlock readback
			`ADDR_SECURITY: secured <= secured | write_data[`SECURITY_BIT];
			default: secured <= secured;
		endcase
	end
end

// ==========================================================
// Cell mode decode
// Globals 0,0 are no listed setting; all drivers stay off there
wire [1:0] cell_mode [0:CELLS-1];
genvar d;
generate
	for (d = 0; d < CELLS; d = d + 1)
	begin : g_mode
		reg [1:0] decoded;
		always @*
		begin
			case ({global_arch_bit_zero, global_arch_bit_one})
				2'b01: decoded = local_arch_bit[d] ?
					`MODE_COMB_IO : `MODE_REG_OUT;
				2'b10: decoded = local_arch_bit[d] ?
					`MODE_INPUT : `MODE_COMB_OUT;
				2'b11: decoded = `MODE_COMB_IO;
				default: decoded = `MODE_INPUT;
			endcase
		end
		assign cell_mode[d] = decoded;
	end
endgenerate

// ==========================================================
// Array input pool
// Pins are resolved outside; a floating pin arrives here as one
wire [CELLS-1:0] feedback;
wire [`SIGNAL_COUNT-1:0] signals;
wire [POOL-1:0] pool;
assign signals = {feedback, in_pin};
assign pool = {~signals, signals};

// ==========================================================
// Status sampled for readback
wire [CELLS-1:0] cell_state;
wire [CELLS-1:0] cell_out;
wire [CELLS-1:0] cell_oe_n;
assign io_out = cell_out;
assign io_oe_n = cell_oe_n;

// ==========================================================
// Macrocells
genvar c;
generate
	for (c = 0; c < CELLS; c = c + 1)
	begin : g_cell
		wire [TERMS*POOL-1:0] masks;
		wire term0_enable;
		genvar t;
		for (t = 0; t < TERMS; t = t + 1)
		begin : g_mask
			assign masks[t*POOL +: POOL] =
				{mask_mem[(c*TERMS+t)*2+1][POOL-33:0],
				mask_mem[(c*TERMS+t)*2]};
		end
		// Only the combinatorial I/O cell spends its first term on enable
		assign term0_enable = (cell_mode[c] == `MODE_COMB_IO);
		macrocell #(
			.TERMS(TERMS),
			.POOL(POOL)
		) u_cell (
			.clock(clock),
			.rst_n(rst_n),
			.pool(pool),
			.term_masks(masks),
			.term_disable_fuse(term_disable_fuse[c*TERMS +: TERMS]),
			.mode(cell_mode[c]),
			.invert(polarity[c]),
			.term0_is_enable(term0_enable),
			.oe_pin_n(oe_pin_n),
			.own_pin(io_in[c]),
			.adjacent_pin(io_in[(c+1)%CELLS]),
			.pin_out(cell_out[c]),
			.pin_oe_n(cell_oe_n[c]),
			.state(cell_state[c]),
			.feedback(feedback[c])
		);
	end
endgenerate

// ==========================================================
// Readback
reg [31:0] next_read;
always @*
begin
	next_read = 32'h00000000;
	if (in_mask_range)
		next_read = mask_mem[mask_index];
	else
	begin
		case (address)
			`ADDR_ARCH:
			begin
				next_read[`ARCH_GLOBAL_ZERO] = global_arch_bit_zero;
				next_read[`ARCH_GLOBAL_ONE] = global_arch_bit_one;
				next_read[`ARCH_LOCAL_LSB +: CELLS] = local_arch_bit;
				next_read[`ARCH_POLARITY_LSB +: CELLS] = polarity;
			end
			`ADDR_TERM_DIS_LO: next_read = term_disable_fuse[31:0];
			`ADDR_TERM_DIS_HI: next_read = term_disable_fuse[63:32];
			`ADDR_SIG_LO: next_read = signature[31:0];
			`ADDR_SIG_HI: next_read = signature[63:32];
			`ADDR_SECURITY: next_read[`SECURITY_BIT] = secured;
			`ADDR_STATUS: next_read = {8'h00, ~cell_oe_n, cell_out,
				cell_state};
			default: next_read = 32'h00000000;
		endcase
	end
	// The logic pattern hides behind the security bit; signature and
	// live status stay visible so a secured part can still be identified
	if (secured && (in_mask_range || address == `ADDR_ARCH ||
		address == `ADDR_TERM_DIS_LO || address == `ADDR_TERM_DIS_HI))
		next_read = 32'h00000000;
end

// Data stand only in the cycle after the strobe
always @(posedge clock)
begin
	if (!rst_n)
		read_data <= 32'h00000000;
	else if (read_strobe)
		read_data <= next_read;
	else
		read_data <= 32'h00000000;
end

endmodule

// *** macrocell_array_checker.sv ***
// Port assertions for the macrocell array top.
// Assumes a bind from the bench file and a shadow of config writes here.
`timescale 1ns/1ns
`include "macrocell_array_map.vh"

module macrocell_array_checker
(
	// Clock and reset
	input wire clock,
	input wire rst_n,
	// Register port
	input wire [`ADDR_WIDTH-1:0] address,
	input wire [31:0] write_data,
	input wire write_strobe,
	input wire read_strobe,
	input wire [31:0] read_data,
	// Pins
	input wire [11:0] in_pin,
	input wire oe_pin_n,
	input wire [7:0] io_in,
	input wire [7:0] io_out,
	input wire [7:0] io_oe_n
);
// ==========================================================
// Shadow of configuration writes
reg [31:0] arch;
reg [31:0] sig_hi;
reg sec;
wire hidden = address <= 9'h07F ||
	(address >= `ADDR_ARCH && address <= `ADDR_TERM_DIS_HI);
wire [7:0] loc = arch[15:8];
always @(posedge clock)
begin
	if (!rst_n)
	begin
		arch <= 32'h00000000;
		sig_hi <= 32'h00000000;
		sec <= 1'b0;
	end
	else if (write_strobe)
	begin
		if (address == `ADDR_ARCH)
			arch <= write_data & `ARCH_WRITE_MASK;
		if (address == `ADDR_SIG_HI)
			sig_hi <= write_data;
		// Only reset clears it, so a written 0 is ignored
		if (address == `ADDR_SECURITY && write_data[0])
			sec <= 1'b1;
	end
end
// ==========================================================
// Assertions
default clocking @(posedge clock); endclocking
default disable iff (!rst_n);
a_reset_pins_high: assert property ($rose(rst_n) |-> io_out == 8'hFF)
	else $error("pins not high after reset");
a_reset_drivers_off: assert property ($rose(rst_n) |-> io_oe_n == 8'hFF)
	else $error("drivers on after reset");
a_read_idle_zero: assert property (!$past(read_strobe) |-> read_data == 0)
	else $error("read data outside its cycle");
a_secured_hidden: assert property (read_strobe && sec && hidden |=> read_data == 0)
	else $error("pattern visible while secured");
a_sig_readback: assert property (read_strobe && address == `ADDR_SIG_HI
	|=> read_data == $past(sig_hi))
	else $error("signature readback wrong");
a_arch_readback: assert property (read_strobe && !sec && address == `ADDR_ARCH
	|=> read_data == $past(arch))
	else $error("architecture readback wrong");
a_all_inputs: assert property (arch[1:0] == 2'b00 |=> io_oe_n == 8'hFF)
	else $error("driver on in input mode");
a_small_modes: assert property (arch[1:0] == 2'b01 |=> io_oe_n == $past(loc))
	else $error("small mode enables wrong");
a_reg_enable: assert property (arch[1:0] == 2'b10 |=> (io_oe_n | $past(loc))
	== ($past(loc) | {8{$past(oe_pin_n)}}))
	else $error("registered enable not from pin");
endmodule

// *** board_glue.sv ***
// Board around the array: resolves each I/O pin from the array's driver.
// Assumes pull-ups on every I/O pin and no other driver on them.
`timescale 1ns/1ns

module board_glue
(
	// Array side
	input wire [7:0] io_out,
	input wire [7:0] io_oe_n,
	// Resolved pins
	output wire [7:0] io_in
);
// Released pin floats up to 1
assign io_in = io_out | io_oe_n;
endmodule

// *** macrocell_array_test.sv ***
// Self-checking bench for the macrocell array over its register port.
// Assumes the board model resolves the I/O pins with pull-ups.
`timescale 1ns/1ns
`include "macrocell_array_map.vh"

module macrocell_array_test;
reg clock = 1'b0;
reg rst_n = 1'b0;
reg [8:0] address = 9'h000;
reg [31:0] write_data = 32'h00000000;
reg write_strobe = 1'b0;
reg read_strobe = 1'b0;
reg [11:0] in_pin = 12'hFFF;
reg oe_pin_n = 1'b1;
wire [31:0] read_data;
wire [7:0] io_in;
wire [7:0] io_out;
wire [7:0] io_oe_n;
integer num_errors = 0;
integer checked = 0;
reg [7:0] last;
always #2 clock = ~clock;
macrocell_array u_macrocell_array(.clock(clock), .rst_n(rst_n),
	.address(address), .write_data(write_data),
	.write_strobe(write_strobe), .read_strobe(read_strobe),
	.read_data(read_data), .in_pin(in_pin), .oe_pin_n(oe_pin_n),
	.io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n));
board_glue u_board_glue(.io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_in));
// ==========================================================
// Tasks
task tally_and_finish;
begin
	$display("checks %0d mismatches %0d", checked, num_errors);
	if (num_errors == 0 && checked > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
end
endtask
task check(input [79:0] name, input [31:0] exp, input [31:0] got);
begin
	checked = checked + 1;
	if (got !== exp)
	begin
		num_errors = num_errors + 1;
		$display("MISMATCH %0s exp %h got %h", name, exp, got);
	end
end
endtask
task wr(input [8:0] a, input [31:0] d);
begin
	@(posedge clock);
	address <= a;
	write_data <= d;
	write_strobe <= 1'b1;
	@(posedge clock);
	write_strobe <= 1'b0;
end
endtask
task rd(input [8:0] a, input [31:0] exp);
begin
	@(posedge clock);
	address <= a;
	read_strobe <= 1'b1;
	@(posedge clock);
	read_strobe <= 1'b0;
	#1 check("read_data", exp, read_data);
end
endtask
// Outputs follow one edge after config takes effect
task pins(input [7:0] eo, input [7:0] ee);
begin
	repeat (2) @(posedge clock);
	#1 check("io_out", eo, io_out);
	check("io_oe_n", ee, io_oe_n);
end
endtask
// ==========================================================
// Tests
initial
begin
	#100000 num_errors = num_errors + 1;
	tally_and_finish;
end
initial
begin
	repeat (8) @(posedge clock);
	rst_n <= 1'b1;
	oe_pin_n <= 1'b0;
	pins(8'hFF, 8'hFF);
	rd(`ADDR_STATUS, 32'h0000FFFF);
	wr(`ADDR_SIG_LO, 32'hA5A5F00F);
	wr(`ADDR_SIG_HI, 32'h5A5A0FF0);
	rd(`ADDR_SIG_LO, 32'hA5A5F00F);
	rd(`ADDR_SIG_HI, 32'h5A5A0FF0);
	wr(`ADDR_ARCH, 32'hFFFFFFFF);
	rd(`ADDR_ARCH, 32'h00FFFF03);
	$display("reset and store test done");
	wr(`ADDR_ARCH, 32'h00000002);
	pins(8'h00, 8'h00);
	rd(`ADDR_STATUS, 32'h00FF00FF);
	@(posedge clock) oe_pin_n <= 1'b1;
	pins(8'h00, 8'hFF);
	wr(`ADDR_TERM_DIS_LO, 32'hFFFFFFFE);
	wr(`ADDR_TERM_DIS_HI, 32'hFFFFFFFF);
	pins(8'hFE, 8'hFF);
	wr(`ADDR_ARCH, 32'h00FF0002);
	pins(8'h01, 8'hFF);
	$display("registered test done");
	wr(`ADDR_ARCH, 32'h00000002);
	wr(9'h001, 32'h00000001);
	repeat (3) @(posedge clock);
	repeat (2)
	begin
		#1 last = io_out;
		@(posedge clock);
		#1 check("io_out", {7'h7F, ~last[0]}, io_out);
	end
	wr(9'h001, 32'h00000000);
	wr(9'h000, 32'h00000001);
	pins(8'hFE, 8'hFF);
	@(posedge clock) in_pin <= 12'hFFE;
	pins(8'hFF, 8'hFF);
	@(posedge clock) in_pin <= 12'hFFF;
	$display("feedback test done");
	wr(`ADDR_ARCH, 32'h0000F001);
	pins(8'h01, 8'hF0);
	wr(`ADDR_ARCH, 32'h0000FF03);
	pins(8'h00, 8'hFE);
	// Cell 0 term 0 now reads its feedback, the pin of cell 1
	wr(9'h000, 32'h00001000);
	wr(`ADDR_ARCH, 32'h00000001);
	pins(8'h00, 8'h00);
	wr(`ADDR_ARCH, 32'h00020001);
	pins(8'h03, 8'h00);
	$display("combinatorial test done");
	wr(`ADDR_SECURITY, 32'h00000001);
	rd(`ADDR_ARCH, 32'h00000000);
	rd(`ADDR_TERM_DIS_LO, 32'h00000000);
	rd(9'h000, 32'h00000000);
	wr(`ADDR_SECURITY, 32'h00000000);
	rd(`ADDR_SECURITY, 32'h00000001);
	rd(`ADDR_TERM_DIS_HI, 32'h00000000);
	rd(`ADDR_SIG_LO, 32'hA5A5F00F);
	rd(9'h107, 32'h00000000);
	$display("security test done");
	@(posedge clock) rst_n <= 1'b0;
	pins(8'hFF, 8'hFF);
	@(posedge clock) rst_n <= 1'b1;
	rd(`ADDR_SECURITY, 32'h00000000);
	rd(`ADDR_STATUS, 32'h0000FFFF);
	$display("mid-run reset test done");
	tally_and_finish;
end
endmodule

bind macrocell_array macrocell_array_checker u_macrocell_array_checker(
	.clock(clock), .rst_n(rst_n), .address(address),
	.write_data(write_data), .write_strobe(write_strobe),
	.read_strobe(read_strobe), .read_data(read_data), .in_pin(in_pin),
	.oe_pin_n(oe_pin_n), .io_in(io_in), .io_out(io_out),
	.io_oe_n(io_oe_n));
